/* dv/timer_ctrl_monitor.sv */
// assertion checker for the shared timer control block
`timescale 1ns/1ps
`default_nettype none
`include "timer_ctrl_map.vh"
module timer_ctrl_monitor (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [`CH_MSB:0] count_tick_i,
    input wire logic [`CH_MSB:0] clear_req_i,
    input wire logic [`NUM_CH*`CNT_W-1:0] channel_counter_o,
    input wire logic complementary_pwm_o,
    input wire logic reset_sync_pwm_o
);
// ==========================================================
// properties
default clocking @(posedge clk_sys_i); endclocking
default disable iff (!resetn_i);
// any bus write may preset, so only quiet cycles are judged
AST_CNT_HOLD: assert property (!count_tick_i[0] && clear_req_i == 5'h00 &&
    !s_axi_awvalid && !s_axi_wvalid |=> $stable(channel_counter_o[15:0]))
    else $error("counter 0 moved without a cause");
AST_PAIR_EXCL: assert property (!(complementary_pwm_o && reset_sync_pwm_o))
    else $error("both combined pwm modes active");
// the pair mode only moves when software writes
AST_PAIR_HOLD: assert property (!s_axi_awvalid && !s_axi_wvalid |=>
    $stable(complementary_pwm_o) && $stable(reset_sync_pwm_o))
    else $error("pair mode changed without a write");
AST_B_STAND: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
AST_R_STAND: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid) else $error("write answer late");
endmodule // timer_ctrl_monitor
bind timer_shared_ctrl timer_ctrl_monitor u_monitor (.clk_sys_i, .resetn_i, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .count_tick_i,
    .clear_req_i, .channel_counter_o, .complementary_pwm_o, .reset_sync_pwm_o);
`default_nettype wire

/* dv/timer_shared_ctrl_bench.sv */
// self-checking bench for the shared timer control block
`timescale 1ns/1ps
`default_nettype none
`include "timer_ctrl_map.vh"
module timer_shared_ctrl_bench;
// ==========================================================
// stimulus, design and addresses (byte address = index * 4)
localparam logic [31:0] RUN = 32'h17FF_FC00, SYNC = 32'h17FF_FC04, MODE = 32'h17FF_FC08;
localparam logic [31:0] PAIR = 32'h17FF_FC0C, STAT = 32'h17FF_FD00, MASK = 32'h17FF_FD04;
localparam logic [31:0] CNT0 = 32'h17FF_FD20, BAD = 32'h17FF_FC40;
logic clk_sys_i = 1'b0;
logic resetn_i = 1'b0;
logic [31:0] aw_addr = 32'h0000_0000, w_data = 32'h0000_0000, ar_addr = 32'h0000_0000;
logic aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0, ar_valid = 1'b0, r_ready = 1'b0;
logic [4:0] tick = 5'h00, clr = 5'h00;
logic ph_a = 1'b0, ph_b = 1'b0;
wire aw_ready, w_ready, b_valid, ar_ready, r_valid, irq, comp, rsync, phase;
wire [1:0] b_resp, r_resp;
wire [31:0] r_data;
wire [79:0] cnt_bus;
wire [4:0] pwm;
wire [3:0] buf_en;
int n_mismatch = 0;
int n_tests = 0;
always #10 clk_sys_i = ~clk_sys_i;
timer_shared_ctrl u_dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .s_axi_awaddr(aw_addr),
    .s_axi_awvalid(aw_valid), .s_axi_awready(aw_ready), .s_axi_wdata(w_data),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(w_valid), .s_axi_wready(w_ready), .s_axi_bresp(b_resp),
    .s_axi_bvalid(b_valid), .s_axi_bready(b_ready), .s_axi_araddr(ar_addr),
    .s_axi_arvalid(ar_valid), .s_axi_arready(ar_ready), .s_axi_rdata(r_data),
    .s_axi_rresp(r_resp), .s_axi_rvalid(r_valid), .s_axi_rready(r_ready),
    .count_tick_i(tick), .clear_req_i(clr), .phase_a_i(ph_a), .phase_b_i(ph_b),
    .channel_counter_o(cnt_bus), .pulse_width_mode_bits_o(pwm), .phase_count_select_o(phase),
    .complementary_pwm_o(comp), .reset_sync_pwm_o(rsync), .buffer_enable_o(buf_en),
    .irq_o(irq));
// ==========================================================
// tasks
task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
        n_mismatch++;
        $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
endtask
task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
    bit aw_done;
    bit w_done;
    @(posedge clk_sys_i);
    aw_addr <= a;
    w_data <= d;
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    b_ready <= 1'b1;
    aw_done = 0;
    w_done = 0;
    while (!(aw_done && w_done)) begin
        @(posedge clk_sys_i);
        if (aw_ready && !aw_done) begin
            aw_done = 1;
            aw_valid <= 1'b0;
        end
        if (w_ready && !w_done) begin
            w_done = 1;
            w_valid <= 1'b0;
        end
    end
    do @(posedge clk_sys_i); while (!b_valid);
    b_ready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, b_resp});
endtask
task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er, input string nm);
    @(posedge clk_sys_i);
    ar_addr <= a;
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    do @(posedge clk_sys_i); while (!ar_ready);
    ar_valid <= 1'b0;
    do @(posedge clk_sys_i); while (!r_valid);
    r_ready <= 1'b0;
    chk(nm, e, r_data);
    chk("rresp", {30'h0, er}, {30'h0, r_resp});
endtask
task automatic run_ticks(input logic [4:0] m, input int n);
    @(posedge clk_sys_i);
    tick <= m;
    repeat (n) @(posedge clk_sys_i);
    tick <= 5'h00;
    @(posedge clk_sys_i);
endtask
task automatic pulse_clear(input logic [4:0] m);
    @(posedge clk_sys_i);
    clr <= m;
    @(posedge clk_sys_i);
    clr <= 5'h00;
    @(posedge clk_sys_i);
endtask
// phase input may pass a sync stage, so allow a few cycles to settle
task automatic set_phase(input logic [1:0] v);
    @(posedge clk_sys_i);
    {ph_a, ph_b} <= v;
    repeat (4) @(posedge clk_sys_i);
endtask
function automatic logic [31:0] cnt(input int n);
    return {16'h0000, cnt_bus[16*n +: 16]};
endfunction
task automatic complete_run;
    $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
        $display("verification passed");
    end else begin
        $display("verification failed");
    end
    $finish;
endtask
// ==========================================================
// table: address, data, read-back, {pwm, phase, comp, rsync, buffers}
typedef struct {logic [31:0] a; logic [31:0] d; logic [7:0] rb; logic [11:0] o;} row_t;
row_t rows[9] = '{'{RUN, 32'h0000_001F, 8'hFF, 12'h000}, '{SYNC, 32'h0000_001F, 8'h7F, 12'h000},
    '{SYNC, 32'h0000_0000, 8'h60, 12'h000}, '{MODE, 32'h0000_007F, 8'h7F, 12'hFC0},
    '{MODE, 32'h0000_0000, 8'h00, 12'h000}, '{PAIR, 32'h0000_003F, 8'h7F, 12'h01F},
    '{PAIR, 32'h0000_0020, 8'h60, 12'h020}, '{PAIR, 32'h0000_0010, 8'h50, 12'h000},
    '{RUN, 32'h0000_0000, 8'hE0, 12'h000}};
initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_mismatch++;
    complete_run();
end
initial begin
    repeat (20) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    foreach (rows[i]) begin
        wr(rows[i].a, rows[i].d);
        rd(rows[i].a, {24'h0, rows[i].rb}, 2'b00, "readback");
        chk("mode outputs", {20'h0, rows[i].o}, {20'h0, pwm, phase, comp, rsync, buf_en});
    end
    wr(BAD, 32'h0000_00FF, `RESP_SLVERR);
    rd(BAD, 32'h0000_0000, `RESP_SLVERR, "unmapped");
    run_ticks(5'h01, 5);
    chk("cnt0 stopped", 32'h0000_0000, cnt(0));
    wr(RUN, 32'h0000_0001);
    run_ticks(5'h01, 3);
    wr(RUN, 32'h0000_0000);
    run_ticks(5'h01, 4);
    wr(RUN, 32'h0000_0001);
    run_ticks(5'h01, 2);
    chk("cnt0 resumed", 32'h0000_0005, cnt(0));
    wr(SYNC, 32'h0000_0003);
    wr(CNT0, 32'h0000_00AB);
    chk("cnt1 sync preset", 32'h0000_00AB, cnt(1));
    chk("cnt2 unsynced", 32'h0000_0000, cnt(2));
    wr(SYNC, 32'h0000_0000);
    pulse_clear(5'h02);
    chk("cnt1 own clear", 32'h0000_0000, cnt(1));
    chk("cnt0 kept", 32'h0000_00AB, cnt(0));
    wr(SYNC, 32'h0000_0003);
    wr(CNT0 + 32'h4, 32'h0000_0055);
    chk("cnt0 sync preset", 32'h0000_0055, cnt(0));
    pulse_clear(5'h01);
    chk("cnt1 sync clear", 32'h0000_0000, cnt(1));
    wr(SYNC, 32'h0000_0000);
    wr(CNT0, 32'h0000_FFFF);
    run_ticks(5'h01, 1);
    chk("cnt0 wrap", 32'h0000_0000, cnt(0));
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(MASK, 32'h0000_0001);
    chk("irq raised", 32'h1, {31'h0, irq});
    rd(STAT, 32'h0000_0001, 2'b00, "status");
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(CNT0 + 32'h8, 32'h0000_0000);
    wr(MODE, 32'h0000_0040);
    wr(MASK, 32'h0000_0004);
    wr(RUN, 32'h0000_0004);
    set_phase(2'b10);
    chk("cnt2 phase down", 32'h0000_FFFF, cnt(2));
    rd(STAT, 32'h0000_0004, 2'b00, "underflow flag");
    wr(RUN, 32'h0000_0000);
    set_phase(2'b00);
    wr(CNT0 + 32'h8, 32'h0000_0000);
    wr(MODE, 32'h0000_0060);
    wr(RUN, 32'h0000_0004);
    set_phase(2'b10);
    chk("cnt2 phase again", 32'h0000_FFFF, cnt(2));
    rd(STAT, 32'h0000_0000, 2'b00, "overflow only");
    set_phase(2'b00);
    chk("cnt2 phase up", 32'h0000_0000, cnt(2));
    rd(STAT, 32'h0000_0004, 2'b00, "overflow flag");
    set_phase(2'b01);
    chk("cnt2 phase b lead", 32'h0000_0001, cnt(2));
    @(posedge clk_sys_i);
    resetn_i <= 1'b0;
    repeat (20) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    rd(RUN, 32'h0000_00E0, 2'b00, "run reset");
    rd(SYNC, 32'h0000_0060, 2'b00, "sync reset");
    rd(MODE, 32'h0000_0000, 2'b00, "mode reset");
    rd(PAIR, 32'h0000_0040, 2'b00, "pair reset");
    chk("cnt2 reset", 32'h0000_0000, cnt(2));
    complete_run();
end
endmodule // timer_shared_ctrl_bench
`default_nettype wire

/* verilog/channel_counter.v */
// one 16-bit channel counter with run gating and load
`timescale 1ns/1ps
`default_nettype none
`include "timer_ctrl_map.vh"

module channel_counter (
    input wire clk_sys_i,
    input wire resetn_i,
    input wire run_i,
    input wire step_i,
    input wire down_i,
    input wire load_i,
    input wire [`CNT_W-1:0] load_val_i,
    output reg [`CNT_W-1:0] count_o,
    output wire wrap_up_o,
    output wire wrap_down_o
);

    wire advance;

    // ==========================================================
    // counting
    assign advance = run_i & step_i & ~load_i; // [R1]
    assign wrap_up_o = advance & ~down_i & (count_o == `CNT_MAX);
    assign wrap_down_o = advance & down_i & (count_o == `CNT_ZERO);

    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_o <= `CNT_ZERO;
        end else if (load_i) begin
            count_o <= load_val_i;
        end else if (advance) begin
            // no else branch: a stopped counter simply keeps its value [R9]
            count_o <= down_i ? count_o - 1'b1 : count_o + 1'b1;
        end
    end

endmodule // channel_counter

`default_nettype wire

/* verilog/timer_ctrl_map.vh */
// register map, field positions and reset values of the shared timer control block
// What this block does
// [R1] counter advances only while its run bit is 1
// [R2] unsynced channel preset/clear stays private to itself
// [R3] synced channels share every preset and clear
// [R4] mode bit 6 puts channel 2 in phase counting
// [R5] mode bit 5: 0 overflow or underflow, 1 overflow
// [R6] mode bits 4..0 select pwm per channel
// [R7] pair code 10 complementary, 11 reset-synchronized pwm
// [R8] low four pair bits enable general/buffer pairing
// [R9] stopped counter holds value and resumes from it
`ifndef TIMER_CTRL_MAP_VH
`define TIMER_CTRL_MAP_VH

// ==========================================================
// register indexes (byte address = index * 4)
`define IDX_RUN_CTRL 30'h5FF_FF00
`define IDX_SYNC_SEL 30'h5FF_FF01
`define IDX_MODE_SEL 30'h5FF_FF02
`define IDX_PAIR_CTRL 30'h5FF_FF03
`define IDX_IRQ_STATUS 30'h5FF_FF40
`define IDX_IRQ_MASK 30'h5FF_FF41
`define IDX_COUNT_BASE 30'h5FF_FF48
`define IDX_COUNT_LAST 30'h5FF_FF4C

// ==========================================================
// decoded register selects
`define SEL_NONE 4'h0
`define SEL_RUN 4'h1
`define SEL_SYNC 4'h2
`define SEL_MODE 4'h3
`define SEL_PAIR 4'h4
`define SEL_STAT 4'h5
`define SEL_MASK 4'h6
`define SEL_CNT 4'h8

// ==========================================================
// fields
`define NUM_CH 5
`define CH_MSB 4
`define CNT_W 16
`define CNT_MAX 16'hFFFF
`define CNT_ZERO 16'h0000
`define MODE_PHASE_BIT 6
`define MODE_OVERFLOW_FLAG_DIRECTION_BIT 5
`define PAIR_MODE_HI 5
`define PAIR_MODE_LO 4
`define PAIR_BUF_MSB 3
`define PAIR_COMPLEMENTARY 2'b10
`define PAIR_RESET_SYNC 2'b11
`define PHASE_CH 2

// ==========================================================
// reset values and fixed read-back bits
`define RUN_RESET 5'h00
`define SYNC_RESET 5'h00
`define MODE_RESET 7'h00
`define PAIR_RESET 6'h00
`define RUN_FILL 8'hE0
`define SYNC_FILL 8'h60
`define MODE_FILL 8'h00
`define PAIR_FILL 8'h40
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* verilog/timer_shared_ctrl.v */
// shared control registers and channel counters of a five-channel timer, axi4-lite slave
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "timer_ctrl_map.vh"

module timer_shared_ctrl (
    input wire clk_sys_i,
    input wire resetn_i,
    // axi4-lite slave
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // timer side
    input wire [`CH_MSB:0] count_tick_i,
    input wire [`CH_MSB:0] clear_req_i,
    input wire phase_a_i,
    input wire phase_b_i,
    output wire [`NUM_CH*`CNT_W-1:0] channel_counter_o,
    output wire [`CH_MSB:0] pulse_width_mode_bits_o,
    output wire phase_count_select_o,
    output wire complementary_pwm_o,
    output wire reset_sync_pwm_o,
    output wire [`PAIR_BUF_MSB:0] buffer_enable_o,
    output wire irq_o
);

    // ==========================================================
    // address decode, shared by read and write paths
    function [3:0] reg_sel;
        input [31:0] addr;
        begin
            reg_sel = `SEL_NONE;
            case (addr[31:2])
                `IDX_RUN_CTRL: reg_sel = `SEL_RUN;
                `IDX_SYNC_SEL: reg_sel = `SEL_SYNC;
                `IDX_MODE_SEL: reg_sel = `SEL_MODE;
                `IDX_PAIR_CTRL: reg_sel = `SEL_PAIR;
                `IDX_IRQ_STATUS: reg_sel = `SEL_STAT;
                `IDX_IRQ_MASK: reg_sel = `SEL_MASK;
                default: begin
                    if (addr[31:2] >= `IDX_COUNT_BASE && addr[31:2] <= `IDX_COUNT_LAST) begin
                        reg_sel = `SEL_CNT;
                    end
                end
            endcase
        end
    endfunction

    // ==========================================================
    // registers
    reg [`CH_MSB:0] run_q;
    reg [`CH_MSB:0] sync_q;
    reg [6:0] mode_q;
    reg [5:0] pair_q;
    reg [`CH_MSB:0] status_q;
    reg [`CH_MSB:0] mask_q;

    // write channel state
    reg aw_held_q;
    reg [31:0] aw_addr_q;
    reg w_held_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;

    wire aw_take;
    wire w_take;
    wire have_aw;
    wire have_w;
    wire wr_fire;
    wire [31:0] wr_addr;
    wire [31:0] wr_data;
    wire [3:0] wr_strb;
    wire [3:0] wr_sel;
    wire [2:0] wr_ch;

    // the slave takes address and data in either order and answers once both are in
    assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held_q & ~s_axi_bvalid;
    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take = s_axi_wvalid & s_axi_wready;
    assign have_aw = aw_held_q | aw_take;
    assign have_w = w_held_q | w_take;
    assign wr_fire = have_aw & have_w;
    assign wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
    assign wr_data = w_held_q ? w_data_q : s_axi_wdata;
    assign wr_strb = w_held_q ? w_strb_q : s_axi_wstrb;
    assign wr_sel = reg_sel(wr_addr);
    assign wr_ch = wr_addr[4:2];

    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 32'h0000_0000;
            w_held_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_sel == `SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
            end else begin
                if (aw_take) begin
                    aw_held_q <= 1'b1;
                    aw_addr_q <= s_axi_awaddr;
                end
                if (w_take) begin
                    w_held_q <= 1'b1;
                    w_data_q <= s_axi_wdata;
                    w_strb_q <= s_axi_wstrb;
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // control register writes; only the low byte lane carries them
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            run_q <= `RUN_RESET; // [R1]
            sync_q <= `SYNC_RESET;
            mode_q <= `MODE_RESET;
            pair_q <= `PAIR_RESET;
            mask_q <= `SYNC_RESET;
        end else if (wr_fire && wr_strb[0]) begin
            case (wr_sel)
                `SEL_RUN: run_q <= wr_data[`CH_MSB:0]; // [R1]
                `SEL_SYNC: sync_q <= wr_data[`CH_MSB:0];
                `SEL_MODE: mode_q <= wr_data[6:0];
                `SEL_PAIR: pair_q <= wr_data[5:0];
                `SEL_MASK: mask_q <= wr_data[`CH_MSB:0];
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // preset and clear distribution
    wire [`CH_MSB:0] preset_req;
    wire [`CH_MSB:0] preset_eff;
    wire [`CH_MSB:0] clear_eff;
    wire [`CNT_W-1:0] preset_val;
    wire sync_preset;
    wire sync_clear;

    assign preset_val = {wr_strb[1] ? wr_data[15:8] : 8'h00, wr_strb[0] ? wr_data[7:0] : 8'h00};
    assign sync_preset = |(preset_req & sync_q); // [R3]
    assign sync_clear = |(clear_req_i & sync_q); // [R3]

    // ==========================================================
    // channel 2 phase decoding
    reg phase_a_q;
    reg phase_b_q;
    wire phase_step;
    wire phase_down;
    wire phase_mode;

    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            phase_a_q <= 1'b0;
            phase_b_q <= 1'b0;
        end else begin
            phase_a_q <= phase_a_i;
            phase_b_q <= phase_b_i;
        end
    end

    assign phase_mode = mode_q[`MODE_PHASE_BIT]; // [R4]
    assign phase_step = (phase_a_q ^ phase_a_i) | (phase_b_q ^ phase_b_i);
    // quadrature: b leading a counts up, a leading b counts down
    assign phase_down = ~(phase_a_q ^ phase_b_i);

    // ==========================================================
    // channel counters
    wire [`CH_MSB:0] wrap_up;
    wire [`CH_MSB:0] wrap_down;
    wire [`CH_MSB:0] event_set;

    genvar ch;
    generate
        for (ch = 0; ch < `NUM_CH; ch = ch + 1) begin : g_ch
            wire use_phase;
            assign use_phase = (ch == `PHASE_CH) && phase_mode; // [R4]
            // own request always counts; group request only when synced [R2]
            assign preset_req[ch] = wr_fire & (wr_sel == `SEL_CNT) & (wr_ch == ch) &
                (|wr_strb[1:0]);
            assign preset_eff[ch] = preset_req[ch] | (sync_q[ch] & sync_preset); // [R2] [R3]
            assign clear_eff[ch] = clear_req_i[ch] | (sync_q[ch] & sync_clear); // [R2] [R3]

            channel_counter u_cnt (
                .clk_sys_i(clk_sys_i),
                .resetn_i(resetn_i),
                .run_i(run_q[ch]), // [R1]
                .step_i(use_phase ? phase_step : count_tick_i[ch]),
                .down_i(use_phase & phase_down),
                .load_i(preset_eff[ch] | clear_eff[ch]),
                .load_val_i(clear_eff[ch] ? `CNT_ZERO : preset_val),
                .count_o(channel_counter_o[ch*`CNT_W +: `CNT_W]),
                .wrap_up_o(wrap_up[ch]),
                .wrap_down_o(wrap_down[ch])
            );

            // only channel 2 counts down; its flag direction picks underflow in or out
            if (ch == `PHASE_CH) begin : g_dir
                assign event_set[ch] = wrap_up[ch] |
                    (wrap_down[ch] & ~mode_q[`MODE_OVERFLOW_FLAG_DIRECTION_BIT]); // [R5]
            end else begin : g_up
                assign event_set[ch] = wrap_up[ch];
            end
        end
    endgenerate

    // ==========================================================
    // read path
    wire ar_take;
    wire [3:0] rd_sel;
    wire [2:0] rd_ch;
    reg [31:0] rd_word;

    assign s_axi_arready = ~s_axi_rvalid;
    assign ar_take = s_axi_arvalid & s_axi_arready;
    assign rd_sel = reg_sel(s_axi_araddr);
    assign rd_ch = s_axi_araddr[4:2];

    always @* begin
        rd_word = 32'h0000_0000;
        case (rd_sel)
            `SEL_RUN: rd_word = {24'h00_0000, `RUN_FILL | {3'b000, run_q}};
            `SEL_SYNC: rd_word = {24'h00_0000, `SYNC_FILL | {3'b000, sync_q}};
            `SEL_MODE: rd_word = {24'h00_0000, `MODE_FILL | {1'b0, mode_q}};
            `SEL_PAIR: rd_word = {24'h00_0000, `PAIR_FILL | {2'b00, pair_q}};
            `SEL_STAT: rd_word = {27'h000_0000, status_q};
            `SEL_MASK: rd_word = {27'h000_0000, mask_q};
            `SEL_CNT: rd_word = {16'h0000, channel_counter_o[rd_ch*`CNT_W +: `CNT_W]};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= (rd_sel == `SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // interrupt status: read clears, a wrap in the same cycle survives
    wire stat_read;
    assign stat_read = ar_take & (rd_sel == `SEL_STAT);

    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            status_q <= `SYNC_RESET;
        end else begin
            status_q <= (stat_read ? `SYNC_RESET : status_q) | event_set;
        end
    end

    assign irq_o = |(status_q & mask_q);

    // ==========================================================
    // mode outputs
    assign pulse_width_mode_bits_o = mode_q[`CH_MSB:0]; // [R6]
    assign phase_count_select_o = phase_mode; // [R4]
    // codes 00 and 01 both leave channels 3 and 4 independent
    assign complementary_pwm_o =
        (pair_q[`PAIR_MODE_HI:`PAIR_MODE_LO] == `PAIR_COMPLEMENTARY); // [R7]
    assign reset_sync_pwm_o = (pair_q[`PAIR_MODE_HI:`PAIR_MODE_LO] == `PAIR_RESET_SYNC); // [R7]
    assign buffer_enable_o = pair_q[`PAIR_BUF_MSB:0]; // [R8]

endmodule // timer_shared_ctrl

`default_nettype wire
